/* File: rtl/sosw_pkg.sv */
// sosw_pkg: field positions, codes and selections of the safety option status words.
// assumes: shared by the status word block and the bench; holds definitions only.
package sosw_pkg;

  // word widths and read selects
  localparam int          WORD_W        = 32;
  localparam logic [0:0]  SEL_FIRST     = 1'h0;  // first status word
  localparam logic [0:0]  SEL_SECOND    = 1'h1;  // second status word

  // first status word field positions
  localparam int          S1_NORMAL     = 0;
  localparam int          S1_SELFTEST   = 1;
  localparam int          S1_TORQUE_OFF = 2;
  localparam int          S1_STOP_ONE   = 3;
  localparam int          S1_OUT_LOW    = 8;
  localparam int          S1_INIT       = 9;
  localparam int          S1_ACK_REQ    = 10;
  localparam int          S1_INT_FAIL   = 11;
  localparam int          S1_RESET_REQ  = 12;
  localparam int          S1_FS_PEND    = 13;
  localparam int          S1_EXT_FAIL   = 14;
  localparam int          S1_FUNC_PEND  = 15;
  localparam int          S1_GEN_RESET  = 16;
  localparam int          S1_CUST_CONF  = 17;
  localparam int          S1_CUST_ABORT = 18;
  localparam int          S1_CUST_REQ   = 19;
  localparam int          S1_TEST_WARN  = 21;
  localparam int          S1_ERR_LSB    = 24;
  localparam int          ERR_W         = 8;

  // second status word field positions
  localparam int          S2_DI_LSB     = 0;
  localparam int          DI_W          = 2;
  localparam int          S2_BLANK      = 4;
  localparam int          S2_BUS_LSB    = 5;
  localparam int          BUS_W         = 3;
  localparam int          S2_BUS_FUNC   = 8;
  localparam int          S2_BUS_LINK   = 9;

  // safe input state encoding
  localparam logic [1:0]  DI_INACTIVE   = 2'h0;
  localparam logic [1:0]  DI_ACTIVE     = 2'h1;
  localparam logic [1:0]  DI_PENDING    = 2'h2;
  localparam logic [1:0]  DI_ERROR      = 2'h3;

  // safe fieldbus support code: none, then four protocol codes
  localparam logic [2:0]  BUS_NONE      = 3'h0;
  localparam logic [2:0]  BUS_MAX       = 3'h4;

  // configurable status word selections
  localparam logic [7:0]  CSW_SEL_FUNC  = 8'h5A;  // selection 90
  localparam logic [7:0]  CSW_SEL_RESET = 8'h5B;  // selection 91

  // reset values
  localparam logic [31:0] WORD_RESET    = 32'h0000_0000;

endpackage : sosw_pkg

/* File: rtl/sosw_status_words.sv */
// sosw_status_words: builds the two read-only safety option status words,
// serves reads of them and drives one mappable bit of the configurable status word.
// assumes: all status inputs come from safety option logic on CLK; no bus is added,
// reads and (refused) writes arrive on a plain select/strobe port.
`timescale 1ns/100ps

// Function
// (R1) Bit 0 high only in normal operation, low on any function, pending or warning.
// (R2) Bit 1 follows the power-up self test state.
// (R3) Bit 2 shows torque off active, bit 3 timed stop one active.
// (R4) Bit 8 zero for safe output at 24 V, one for 0 V.
// (R5) Bit 9 set while the option is initialized.
// (R6) Bit 10 requests operator acknowledgement; the controller supplies it.
// (R7) Bit 11 high while an internal failure is active.
// (R8) Bit 12 set while a safety option reset is required.
// (R9) Bit 13 flags a pending fail-safe state, entered at every power-up.
// (R10) Bit 14 high while an external failure is active.
// (R11) Bit 15 set while a safe function is pending.
// (R12) Bit 16 flags that a general reset was performed.
// (R13) Bits 17, 18, 19 flag customisation confirmed, aborted, requested.
// (R14) Bit 21 flags a power-up self test warning.
// (R15) Top byte of the first word carries the error code.
// (R16) Second word bits 1:0 give the safe input state.
// (R17) Second word bit 4 set in the blank initial state.
// (R18) Second word bits 7:5 give the supported safe fieldbus code.
// (R19) Bit 8 safe function active with link up, bit 9 link established.
// (R20) A status word bit may map to selection 91 reset or 90 function.
// (R21) First word readable from every interface, never writable, mappable as process data.
// (R22) Reserved bits read zero and writes never change them.
module sosw_status_words #(
  parameter logic [2:0] SAFE_BUS_CODE = 3'h0              // supported safe fieldbus code
) (
  input  wire logic        CLK,                           // system clock, 100 MHz
  input  wire logic        SRST,                          // synchronous reset, active high
  // live state of the safety option
  input  wire logic        SELF_TEST,                     // power-up self test running
  input  wire logic        TORQUE_OFF,                    // torque-off function active
  input  wire logic        STOP_ONE,                      // timed stop one function active
  input  wire logic        FAILSAFE_REACT,                // fail-safe reaction active
  input  wire logic        WARNING,                       // a warning is active
  input  wire logic        OUT_LOW,                       // safe output sits at 0 V
  input  wire logic        INITIALIZED,                   // option in initialized state
  input  wire logic        ACK_REQ,                       // operator acknowledgement needed
  input  wire logic        INT_FAIL,                      // internal failure active
  input  wire logic        EXT_FAIL,                      // external failure active
  input  wire logic        RESET_REQ,                     // safety option reset required
  input  wire logic        FS_PEND_SET,                   // pulse: fail-safe pending entered
  input  wire logic        FS_PEND_CLR,                   // pulse: fail-safe pending left
  input  wire logic        FUNC_PEND,                     // a safe function is pending
  input  wire logic [7:0]  ERR_CODE,                      // reason of internal/external error
  // event pulses
  input  wire logic        EV_GEN_RESET,                  // pulse: general reset done
  input  wire logic        EV_CUST_CONF,                  // pulse: customisation confirmed
  input  wire logic        EV_CUST_ABORT,                 // pulse: customisation aborted
  input  wire logic        EV_CUST_REQ,                   // pulse: customisation requested
  input  wire logic        EV_TEST_WARN,                  // pulse: self test warning issued
  // second word sources
  input  wire logic [1:0]  SAFE_INPUT_STATE,              // safe digital input state code
  input  wire logic        BLANK_STATE,                   // blank initial state
  input  wire logic        BUS_LINK,                      // safe fieldbus link established
  input  wire logic        BUS_FUNC,                      // safe function activated on bus
  // configurable status word mapping
  input  wire logic [7:0]  CSW_SEL,                       // selection for the mapped bit
  // register access port
  input  wire logic        RD_EN,                         // read strobe
  input  wire logic        RD_SEL,                        // 0 first word, 1 second word
  input  wire logic        WR_EN,                         // write strobe, always refused
  output logic [31:0]      RD_DATA,                       // read data, registered
  output logic             RD_VALID,                      // pulse: read data valid
  output logic             WR_REJECT,                     // pulse: write refused
  // process data and mapped bit
  output logic [31:0]      STATUS_FIRST,                  // first status word, live copy
  output logic [31:0]      STATUS_SECOND,                 // second status word, live copy
  output logic             CSW_BIT                        // mapped configurable status word bit
);

  logic [31:0] next_first;                                // combined first word
  logic [31:0] next_second;                               // combined second word
  logic        fs_pend;                                   // fail-safe pending flag
  logic        ev_gen_reset;                              // sticky event flags
  logic        ev_cust_conf;
  logic        ev_cust_abort;
  logic        ev_cust_req;
  logic        ev_test_warn;
  logic        rd_first;                                  // read of first word this cycle
  logic        safe_func_active;                          // any safe function active
  logic        normal_op;                                 // normal operation condition
  logic [2:0]  bus_code;                                  // bus support code, none when out of range

  // a read of the first word consumes its event flags
  assign rd_first = RD_EN && (RD_SEL == sosw_pkg::SEL_FIRST);

  // (R20) safe function active flag
  assign safe_func_active = TORQUE_OFF | STOP_ONE;

  // (R1) normal only with nothing active or pending
  assign normal_op = ~(safe_func_active | FAILSAFE_REACT | fs_pend | FUNC_PEND | WARNING);

  // (R18) out-of-range codes report no bus
  assign bus_code = (SAFE_BUS_CODE > sosw_pkg::BUS_MAX) ? sosw_pkg::BUS_NONE : SAFE_BUS_CODE;

  // (R9) pending fail-safe entered at power-up
  always_ff @(posedge CLK) begin
    if (SRST) begin
      fs_pend <= 1'b1;
    end else if (FS_PEND_SET) begin
      fs_pend <= 1'b1;
    end else if (FS_PEND_CLR) begin
      fs_pend <= 1'b0;
    end
  end

  // (R12) general reset event, set wins over read clear
  always_ff @(posedge CLK) begin
    if (SRST) begin
      ev_gen_reset <= 1'b0;
    end else if (EV_GEN_RESET) begin
      ev_gen_reset <= 1'b1;
    end else if (rd_first) begin
      ev_gen_reset <= 1'b0;
    end
  end

  // (R13) customisation confirmed event
  always_ff @(posedge CLK) begin
    if (SRST) begin
      ev_cust_conf <= 1'b0;
    end else if (EV_CUST_CONF) begin
      ev_cust_conf <= 1'b1;
    end else if (rd_first) begin
      ev_cust_conf <= 1'b0;
    end
  end

  // (R13) customisation aborted event
  always_ff @(posedge CLK) begin
    if (SRST) begin
      ev_cust_abort <= 1'b0;
    end else if (EV_CUST_ABORT) begin
      ev_cust_abort <= 1'b1;
    end else if (rd_first) begin
      ev_cust_abort <= 1'b0;
    end
  end

  // (R13) customisation requested event
  always_ff @(posedge CLK) begin
    if (SRST) begin
      ev_cust_req <= 1'b0;
    end else if (EV_CUST_REQ) begin
      ev_cust_req <= 1'b1;
    end else if (rd_first) begin
      ev_cust_req <= 1'b0;
    end
  end

  // (R14) self test warning event
  always_ff @(posedge CLK) begin
    if (SRST) begin
      ev_test_warn <= 1'b0;
    end else if (EV_TEST_WARN) begin
      ev_test_warn <= 1'b1;
    end else if (rd_first) begin
      ev_test_warn <= 1'b0;
    end
  end

  // assemble the first word; unlisted bits stay zero
  always_comb begin
    next_first = sosw_pkg::WORD_RESET;
    // (R1) normal operation
    next_first[sosw_pkg::S1_NORMAL]     = normal_op;
    // (R2) self test state
    next_first[sosw_pkg::S1_SELFTEST]   = SELF_TEST;
    // (R3) active safe functions
    next_first[sosw_pkg::S1_TORQUE_OFF] = TORQUE_OFF;
    next_first[sosw_pkg::S1_STOP_ONE]   = STOP_ONE;
    // (R4) one means output at 0 V
    next_first[sosw_pkg::S1_OUT_LOW]    = OUT_LOW;
    // (R5) initialized state
    next_first[sosw_pkg::S1_INIT]       = INITIALIZED;
    // (R6) acknowledgement request to the controller
    next_first[sosw_pkg::S1_ACK_REQ]    = ACK_REQ;
    // (R7) internal failure
    next_first[sosw_pkg::S1_INT_FAIL]   = INT_FAIL;
    // (R8) reset required
    next_first[sosw_pkg::S1_RESET_REQ]  = RESET_REQ;
    // (R9) fail-safe pending
    next_first[sosw_pkg::S1_FS_PEND]    = fs_pend;
    // (R10) external failure
    next_first[sosw_pkg::S1_EXT_FAIL]   = EXT_FAIL;
    // (R11) safe function pending
    next_first[sosw_pkg::S1_FUNC_PEND]  = FUNC_PEND;
    // (R12) general reset event
    next_first[sosw_pkg::S1_GEN_RESET]  = ev_gen_reset;
    // (R13) customisation events
    next_first[sosw_pkg::S1_CUST_CONF]  = ev_cust_conf;
    next_first[sosw_pkg::S1_CUST_ABORT] = ev_cust_abort;
    next_first[sosw_pkg::S1_CUST_REQ]   = ev_cust_req;
    // (R14) self test warning event
    next_first[sosw_pkg::S1_TEST_WARN]  = ev_test_warn;
    // (R15) error code in top byte
    next_first[sosw_pkg::S1_ERR_LSB +: sosw_pkg::ERR_W] = ERR_CODE;
  end

  // assemble the second word; unlisted bits stay zero
  always_comb begin
    next_second = sosw_pkg::WORD_RESET;
    // (R16) safe input state code
    next_second[sosw_pkg::S2_DI_LSB +: sosw_pkg::DI_W]   = SAFE_INPUT_STATE;
    // (R17) blank initial state
    next_second[sosw_pkg::S2_BLANK]                      = BLANK_STATE;
    // (R18) supported bus code
    next_second[sosw_pkg::S2_BUS_LSB +: sosw_pkg::BUS_W] = bus_code;
    // (R19) function on bus needs the link up
    next_second[sosw_pkg::S2_BUS_FUNC]                   = BUS_FUNC & BUS_LINK;
    next_second[sosw_pkg::S2_BUS_LINK]                   = BUS_LINK;
  end

  // (R21) live process data copies
  always_ff @(posedge CLK) begin
    if (SRST) begin
      STATUS_FIRST  <= sosw_pkg::WORD_RESET;
      STATUS_SECOND <= sosw_pkg::WORD_RESET;
    end else begin
      STATUS_FIRST  <= next_first;
      STATUS_SECOND <= next_second;
    end
  end

  // (R21) read port returns the word as seen this cycle
  always_ff @(posedge CLK) begin
    if (SRST) begin
      RD_DATA  <= sosw_pkg::WORD_RESET;
      RD_VALID <= 1'b0;
    end else begin
      RD_VALID <= RD_EN;
      if (RD_EN) begin
        RD_DATA <= (RD_SEL == sosw_pkg::SEL_SECOND) ? next_second : next_first;
      end
    end
  end

  // (R22) writes change nothing and are flagged as refused
  always_ff @(posedge CLK) begin
    if (SRST) begin
      WR_REJECT <= 1'b0;
    end else begin
      WR_REJECT <= WR_EN;
    end
  end

  // (R20) mapped configurable status word bit
  always_ff @(posedge CLK) begin
    if (SRST) begin
      CSW_BIT <= 1'b0;
    end else begin
      case (CSW_SEL)
        sosw_pkg::CSW_SEL_FUNC: begin
          CSW_BIT <= safe_func_active;
        end
        sosw_pkg::CSW_SEL_RESET: begin
          CSW_BIT <= RESET_REQ;
        end
        default: begin
          CSW_BIT <= 1'b0;                                // other selections not served here
        end
      endcase
    end
  end

endmodule : sosw_status_words

/* File: sim/sosw_status_words_chk.sv */
// sosw_status_words_chk: concurrent checks on the ports of the status word block.
// assumes: bound to every sosw_status_words; all signals on CLK, SRST synchronous.
`timescale 1ns/100ps
module sosw_status_words_chk #(
  parameter logic [2:0] SAFE_BUS_CODE = 3'h0                                // supported safe fieldbus code
) (
  input wire logic        CLK, SRST,                                        // clock and reset
  input wire logic        SELF_TEST, TORQUE_OFF, STOP_ONE, FAILSAFE_REACT,  // safe function state
  input wire logic        WARNING, OUT_LOW, INITIALIZED, ACK_REQ, INT_FAIL, // state levels
  input wire logic        EXT_FAIL, RESET_REQ, FUNC_PEND, EV_GEN_RESET,     // state levels and event
  input wire logic [7:0]  ERR_CODE,                                         // error code
  input wire logic [1:0]  SAFE_INPUT_STATE,                                 // safe input code
  input wire logic        BLANK_STATE, BUS_LINK, BUS_FUNC,                  // second word sources
  input wire logic [7:0]  CSW_SEL,                                          // mapped bit selection
  input wire logic        RD_EN, RD_SEL, WR_EN, RD_VALID, WR_REJECT,        // access port
  input wire logic [31:0] RD_DATA, STATUS_FIRST, STATUS_SECOND,             // words
  input wire logic        CSW_BIT                                           // mapped bit
);
  // out-of-range fieldbus codes report none
  localparam logic [2:0] BUS_CODE = (SAFE_BUS_CODE > 3'h4) ? 3'h0 : SAFE_BUS_CODE;
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  AST_NORMAL: assert property (!$past(SRST) &&
    $past(TORQUE_OFF | STOP_ONE | FAILSAFE_REACT | FUNC_PEND | WARNING) |-> !STATUS_FIRST[0])
    else $error("normal bit high during a function or warning");
  AST_FUNC_BITS: assert property (!$past(SRST) |->
    STATUS_FIRST[3:1] == $past({STOP_ONE, TORQUE_OFF, SELF_TEST})) else $error("function bits wrong");
  AST_LEVEL_BITS: assert property (!$past(SRST) |->
    {STATUS_FIRST[15:14], STATUS_FIRST[12:8]} ==
    $past({FUNC_PEND, EXT_FAIL, RESET_REQ, INT_FAIL, ACK_REQ, INITIALIZED, OUT_LOW}))
    else $error("level bits wrong");
  AST_ERR_CODE: assert property (!$past(SRST) |-> STATUS_FIRST[31:24] == $past(ERR_CODE))
    else $error("error code byte wrong");
  AST_RESERVED: assert property ({STATUS_FIRST[23:22], STATUS_FIRST[20], STATUS_FIRST[7:4],
    STATUS_SECOND[31:10], STATUS_SECOND[3:2]} == 31'h0) else $error("reserved bit set");
  AST_SECOND: assert property (!$past(SRST) |-> STATUS_SECOND[9:0] == {$past(BUS_LINK),
    $past(BUS_FUNC & BUS_LINK), BUS_CODE, $past(BLANK_STATE), 2'h0, $past(SAFE_INPUT_STATE)})
    else $error("second word wrong");
  AST_CSW: assert property (!$past(SRST) |-> CSW_BIT == $past(CSW_SEL == sosw_pkg::CSW_SEL_FUNC ?
    (TORQUE_OFF | STOP_ONE) : (CSW_SEL == sosw_pkg::CSW_SEL_RESET) && RESET_REQ)) else $error("mapped bit wrong");
  AST_RD_VALID: assert property (!$past(SRST) |-> RD_VALID == $past(RD_EN))
    else $error("read valid not one cycle after strobe");
  // a write leaves the second word alone while its sources hold still
  AST_WR_REJECT: assert property (WR_EN && !$past(SRST) &&
    $stable({SAFE_INPUT_STATE, BLANK_STATE, BUS_LINK, BUS_FUNC}) |=> WR_REJECT && $stable(STATUS_SECOND))
    else $error("write not refused");
  AST_RD_SECOND: assert property (RD_EN && RD_SEL |=> RD_DATA == STATUS_SECOND)
    else $error("second word read data wrong");
  AST_EVENT: assert property (EV_GEN_RESET |-> ##[1:2] STATUS_FIRST[16])
    else $error("general reset flag not raised");
  AST_FS_PEND: assert property ($fell(SRST) |=> STATUS_FIRST[13] && !STATUS_FIRST[0])
    else $error("fail-safe pending not set after reset");
endmodule : sosw_status_words_chk
bind sosw_status_words sosw_status_words_chk #(.SAFE_BUS_CODE(SAFE_BUS_CODE)) i_sosw_status_words_chk (
  .CLK, .SRST, .SELF_TEST, .TORQUE_OFF, .STOP_ONE, .FAILSAFE_REACT, .WARNING, .OUT_LOW, .INITIALIZED,
  .ACK_REQ, .INT_FAIL, .EXT_FAIL, .RESET_REQ, .FUNC_PEND, .EV_GEN_RESET, .ERR_CODE, .SAFE_INPUT_STATE,
  .BLANK_STATE, .BUS_LINK, .BUS_FUNC, .CSW_SEL, .RD_EN, .RD_SEL, .WR_EN, .RD_VALID, .WR_REJECT, .RD_DATA,
  .STATUS_FIRST, .STATUS_SECOND, .CSW_BIT);

/* File: sim/sosw_reader.sv */
// sosw_reader: model of the process data reader on the safe fieldbus side.
// assumes: same clock as the status word block; reads are one-cycle strobes.
`timescale 1ns/100ps
module sosw_reader (
  input  wire logic        clk,          // system clock
  input  wire logic        rd_valid,     // read data valid
  input  wire logic [31:0] rd_data,      // read data
  input  wire logic [31:0] status_first, // first word process data
  output logic             rd_en,        // read strobe
  output logic             rd_sel,       // word select
  output logic             ack           // operator acknowledgement
);
  initial begin
    rd_en = 1'b0;
    rd_sel = 1'b1;
  end
  always @(posedge clk) ack <= status_first[10];
  // one read: strobe for one cycle, select inverted when idle, then take the answer
  task automatic read(input logic sel, output logic [31:0] data);
    int n;
    n = 0;
    @(negedge clk);
    rd_en = 1'b1;
    rd_sel = sel;
    @(negedge clk);
    rd_en = 1'b0;
    rd_sel = ~sel;
    while (rd_valid !== 1'b1 && n < 4) begin
      @(negedge clk);
      n++;
    end
    data = rd_data;
  endtask : read
endmodule : sosw_reader

/* File: sim/sosw_status_words_tb_top.sv */
// sosw_status_words_tb_top: self-checking bench for the safety option status words.
// assumes: package, block, checker and reader model compiled before it.
`timescale 1ns/100ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin failures++; \
  $display("mismatch at %0t got %h exp %h", $time, got, exp); end end
module sosw_status_words_tb_top;
  typedef struct {logic [31:0] f; logic [31:0] s; logic [2:0] x; logic [7:0] sel; logic csw;} sosw_row_t;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [31:0] f, s, sf, ss, rd_data, d;   // f and s drive level inputs at their own bit places
  logic [2:0]  x;                          // bus function, warning, fail-safe reaction
  logic [7:0]  sel;
  logic [4:0]  ev;
  logic [1:0]  fp;
  logic        wr_en, rd_en, rd_sel, rd_valid, wr_rej, csw;
  int          failures = 0, total_checks = 0;
  sosw_row_t   rows [9] = '{
    '{32'h0000_0001, 32'h0000_0060, 3'h0, 8'h5A, 1'b0}, '{32'h0000_0004, 32'h0000_0060, 3'h0, 8'h5A, 1'b1},
    '{32'h0000_0008, 32'h0000_0060, 3'h0, 8'h5B, 1'b0}, '{32'h0000_1001, 32'h0000_0060, 3'h0, 8'h5B, 1'b1},
    '{32'hA500_4F01, 32'h0000_0363, 3'h4, 8'h00, 1'b0}, '{32'h0000_8002, 32'h0000_0072, 3'h4, 8'h5A, 1'b0},
    '{32'h0000_0000, 32'h0000_0061, 3'h2, 8'h5A, 1'b0}, '{32'h0000_0000, 32'h0000_0260, 3'h1, 8'h5B, 1'b0},
    '{32'h0000_0008, 32'h0000_0060, 3'h0, 8'h5A, 1'b1}};
  always #5 clk = ~clk;
  sosw_status_words #(.SAFE_BUS_CODE(3'h3)) i_sosw_status_words (
    .CLK(clk), .SRST(srst), .SELF_TEST(f[1]), .TORQUE_OFF(f[2]), .STOP_ONE(f[3]), .FAILSAFE_REACT(x[0]),
    .WARNING(x[1]), .OUT_LOW(f[8]), .INITIALIZED(f[9]), .ACK_REQ(f[10]), .INT_FAIL(f[11]), .EXT_FAIL(f[14]),
    .RESET_REQ(f[12]), .FS_PEND_SET(fp[0]), .FS_PEND_CLR(fp[1]), .FUNC_PEND(f[15]), .ERR_CODE(f[31:24]),
    .EV_GEN_RESET(ev[0]), .EV_CUST_CONF(ev[1]), .EV_CUST_ABORT(ev[2]), .EV_CUST_REQ(ev[3]),
    .EV_TEST_WARN(ev[4]), .SAFE_INPUT_STATE(s[1:0]), .BLANK_STATE(s[4]), .BUS_LINK(s[9]), .BUS_FUNC(x[2]),
    .CSW_SEL(sel), .RD_EN(rd_en), .RD_SEL(rd_sel), .WR_EN(wr_en), .RD_DATA(rd_data), .RD_VALID(rd_valid),
    .WR_REJECT(wr_rej), .STATUS_FIRST(sf), .STATUS_SECOND(ss), .CSW_BIT(csw));
  sosw_reader i_sosw_reader (.clk(clk), .rd_valid(rd_valid), .rd_data(rd_data), .status_first(sf),
    .rd_en(rd_en), .rd_sel(rd_sel), .ack());
  // verdict and end of run
  task automatic report_and_stop;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  // watchdog against a hung run
  initial begin
    repeat (1000) @(posedge clk);
    failures++;
    report_and_stop();
  end
  // main sequence
  initial begin
    f = '0; s = '0; x = '0; sel = '0; ev = '0; fp = '0; wr_en = 1'b0;
    repeat (20) @(negedge clk);
    srst = 1'b0;
    @(negedge clk); fp = 2'h2; @(negedge clk); fp = 2'h0;
    foreach (rows[i]) begin
      f = rows[i].f; s = rows[i].s; x = rows[i].x; sel = rows[i].sel;
      @(negedge clk);
      `CHK(sf, rows[i].f)
      `CHK(ss, rows[i].s)
      `CHK(csw, rows[i].csw)
    end
    i_sosw_reader.read(1'b1, d);
    `CHK(rd_valid, 1'b1)
    `CHK(d, rows[8].s)
    wr_en = 1'b1; @(negedge clk); wr_en = 1'b0;
    `CHK(wr_rej, 1'b1)
    @(negedge clk);
    `CHK(sf, rows[8].f)
    // one event of each kind, then a clearing read
    for (int i = 0; i < 5; i++) begin
      ev = 5'h01 << i;
      @(negedge clk);
    end
    ev = '0; repeat (2) @(negedge clk);
    `CHK(sf[23:16], 8'h2F)
    i_sosw_reader.read(1'b0, d);
    `CHK(d[23:16], 8'h2F)
    repeat (2) @(negedge clk);
    `CHK(sf[23:16], 8'h00)
    // event arriving in the clearing cycle survives
    fork
      i_sosw_reader.read(1'b0, d);
      begin
        @(negedge clk); ev = 5'h08; @(negedge clk); ev = 5'h00;
      end
    join
    repeat (2) @(negedge clk);
    `CHK(sf[19], 1'b1)
    // second reset in mid-run
    srst = 1'b1; repeat (2) @(negedge clk);
    `CHK(sf, 32'h0000_0000)
    srst = 1'b0; f = '0; x = '0; @(negedge clk);
    @(negedge clk);
    `CHK(sf, 32'h0000_2000)
    // clear the pending flag, then set and clear together: set wins
    fp = 2'h2;
    @(negedge clk);
    fp = 2'h3;
    @(negedge clk);
    `CHK(sf, 32'h0000_0001)
    fp = 2'h0;
    @(negedge clk);
    `CHK(sf, 32'h0000_2000)
    report_and_stop();
  end
endmodule : sosw_status_words_tb_top
